// [core/uifc_pkg.sv]
// constants for the interrupt-enable / fifo-control register slice
// assumes a 16-deep receive and transmit fifo outside this block
package uifc_pkg;
    // byte addresses on the register port
    localparam logic [31:0] ADDR_IER_DLH = 32'h5000_1104;
    localparam logic [31:0] ADDR_IIR_FCR = 32'h5000_1108;
    localparam logic [31:0] ADDR_LCR = 32'h5000_110c;
    localparam logic [31:0] ADDR_CTRL = 32'h5000_1110;
    localparam logic [31:0] ADDR_STATUS = 32'h5000_1114;

    // interrupt-enable fields
    localparam int IER_RX_DATA_BIT = 0;
    localparam int IER_TX_EMPTY_BIT = 1;
    localparam int IER_LINE_BIT = 2;
    localparam logic [2:0] IER_RESET = 3'h0;
    localparam logic [7:0] DIV_HIGH_RESET = 8'h00;

    // fifo-control fields
    localparam int FCR_RX_THR_LSB = 6;
    localparam int FCR_TX_THR_LSB = 4;
    localparam int FCR_DMA_MODE_BIT = 3;
    localparam logic [1:0] THR_RESET = 2'h0;
    localparam logic [1:0] FIFO_STATUS_ON = 2'h3;
    localparam logic [1:0] FIFO_STATUS_OFF = 2'h0;

    // line control and own control fields
    localparam int LCR_DIV_ACCESS_BIT = 7;
    localparam int CTRL_FIFO_EN_BIT = 0;
    localparam int CTRL_AUTO_FLOW_BIT = 1;
    localparam int CTRL_RTS_REQ_BIT = 2;
    localparam logic [7:0] LCR_RESET = 8'h00;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // fifo depth and threshold levels
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    localparam logic [4:0] RX_LVL_ONE = 5'h01;
    localparam logic [4:0] RX_LVL_QUARTER = FIFO_DEPTH >> 2;
    localparam logic [4:0] RX_LVL_HALF = FIFO_DEPTH >> 1;
    localparam logic [4:0] RX_LVL_NEAR_FULL = FIFO_DEPTH - 5'h02;
    localparam logic [4:0] TX_LVL_EMPTY = 5'h00;
    localparam logic [4:0] TX_LVL_TWO = 5'h02;
    localparam logic [4:0] TX_LVL_QUARTER = FIFO_DEPTH >> 2;
    localparam logic [4:0] TX_LVL_HALF = FIFO_DEPTH >> 1;

    localparam int DATA_W = 8;

    // highest pending enabled source
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_LINE = 2'b01,
        SRC_RX_DATA = 2'b10,
        SRC_TX_EMPTY = 2'b11
    } uifc_src_t;
endpackage

// [core/uifc_stream_if.sv]
// valid/ready stream between the top and its two-entry buffer
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface uifc_stream_if;
    logic in_valid;
    logic [7:0] in_data;
    logic in_ready;
    logic out_valid;
    logic [7:0] out_data;
    logic out_ready;
    modport buffer (
        input in_valid,
        input in_data,
        output in_ready,
        output out_valid,
        output out_data,
        input out_ready
    );
    modport user (
        output in_valid,
        output in_data,
        input in_ready,
        input out_valid,
        input out_data,
        output out_ready
    );
endinterface
`default_nettype wire

// [core/uifc_buffer.sv]
// two-entry buffer: head register feeds the output directly
// assumes same clock and synchronous active-high reset as the top
`timescale 1ns/1ps
`default_nettype none
module uifc_buffer (
    input wire logic clk,
    input wire logic rst,
    uifc_stream_if.buffer st
);
    logic [7:0] head_ff;
    logic [7:0] tail_ff;
    logic [1:0] count_ff;
    logic [1:0] nxt_count;
    logic in_ready_ff;
    logic out_valid_ff;
    logic push;
    logic pop;

    assign push = st.in_valid & in_ready_ff;
    assign pop = out_valid_ff & st.out_ready;
    assign nxt_count = count_ff + {1'b0, push} - {1'b0, pop};
    assign st.in_ready = in_ready_ff;
    assign st.out_valid = out_valid_ff;
    assign st.out_data = head_ff;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_ff <= 2'h0;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            in_ready_ff <= (nxt_count != 2'h2);
            out_valid_ff <= (nxt_count != 2'h0);
        end
    end

    // head loads from input when empty or draining, else from tail
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            head_ff <= 8'h00;
            tail_ff <= 8'h00;
        end
        else
        begin
            if (pop && count_ff == 2'h2)
                head_ff <= tail_ff;
            else if (push && (count_ff == 2'h0 || pop))
                head_ff <= st.in_data;
            if (push && count_ff == 2'h1 && !pop)
                tail_ff <= st.in_data;
        end
    end
endmodule
`default_nettype wire

// [core/uifc_top.sv]
// interrupt enables, divisor high byte and fifo thresholds of a uart
// assumes fifo levels and pending events come from logic on SYS_CLK
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - tx holding empty interrupt passes only when its enable is set; third rank
// - the enable address also holds the divisor high byte, read and write
// - divisor access bit set selects divisor byte, otherwise the enables
// - rx data enable gates rx data and, with fifos on, char timeout
// - rx data and char timeout rank second in priority
// - fifo-control bits 7:6 read 11 with fifos on, 00 when off
// - write bits 7:6 pick rx threshold: 1, quarter, half, two below full
// - auto flow, with fifos on, deasserts request-to-send at the rx threshold
// - rx dma request (active low) follows the rx threshold in mode 1 with fifos on, any character in mode 0
// - bits 5:4 pick tx empty threshold; read back as zero
// - line status interrupt, own enable, has top priority
module uifc_top (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic [4:0] RX_FIFO_LEVEL,
    input wire logic [4:0] TX_FIFO_LEVEL,
    input wire logic LINE_STATUS_EVENT,
    input wire logic CHAR_TIMEOUT_EVENT,
    input wire logic RX_IN_VALID,
    input wire logic [7:0] RX_IN_DATA,
    output logic RX_IN_READY,
    output logic RX_OUT_VALID,
    output logic [7:0] RX_OUT_DATA,
    input wire logic RX_OUT_READY,
    output logic IRQ,
    output logic [1:0] IRQ_SOURCE,
    output logic RTS_N,
    output logic DMA_RX_REQ_N,
    output logic DMA_TX_REQ_N,
    output logic [7:0] DIVISOR_HIGH,
    output logic [1:0] RX_THRESHOLD,
    output logic [1:0] TX_THRESHOLD
);
    // register state
    logic [2:0] irq_en_ff;
    logic [7:0] div_high_ff;
    logic [1:0] rx_thr_ff;
    logic [1:0] tx_thr_ff;
    logic dma_mode_ff;
    logic [7:0] lcr_ff;
    logic [2:0] ctrl_ff;
    logic [31:0] rdata_ff;

    // output state
    logic irq_ff;
    uifc_pkg::uifc_src_t src_ff;
    logic rts_n_ff;
    logic dma_rx_n_ff;
    logic dma_tx_n_ff;

    // decode
    logic hit_ier;
    logic hit_fcr;
    logic hit_lcr;
    logic hit_ctrl;
    logic hit_status;
    logic div_access;
    logic wr_ier;
    logic wr_div;
    logic wr_fcr;
    logic wr_lcr;
    logic wr_ctrl;

    // control bits
    logic fifo_en;
    logic auto_flow;
    logic rts_req;

    // levels and pending sources
    logic [4:0] rx_level;
    logic [4:0] tx_level;
    logic rx_at_thr;
    logic tx_at_thr;
    logic rx_any;
    logic tx_empty;
    logic line_pend;
    logic rx_pend;
    logic timeout_pend;
    logic txe_pend;
    logic line_on;
    logic rx_on;
    logic txe_on;
    uifc_pkg::uifc_src_t nxt_src;
    logic nxt_irq;
    logic nxt_rts_n;
    logic nxt_dma_rx_n;
    logic nxt_dma_tx_n;

    // read data
    logic [7:0] ier_view;
    logic [7:0] fcr_view;
    logic [7:0] status_view;
    logic [31:0] nxt_rdata;

    assign hit_ier = (REG_ADDR == uifc_pkg::ADDR_IER_DLH);
    assign hit_fcr = (REG_ADDR == uifc_pkg::ADDR_IIR_FCR);
    assign hit_lcr = (REG_ADDR == uifc_pkg::ADDR_LCR);
    assign hit_ctrl = (REG_ADDR == uifc_pkg::ADDR_CTRL);
    assign hit_status = (REG_ADDR == uifc_pkg::ADDR_STATUS);

    assign div_access = lcr_ff[uifc_pkg::LCR_DIV_ACCESS_BIT];
    // same address, two targets, steered by the access bit
    assign wr_div = REG_WR & hit_ier & div_access;
    assign wr_ier = REG_WR & hit_ier & ~div_access;
    assign wr_fcr = REG_WR & hit_fcr;
    assign wr_lcr = REG_WR & hit_lcr;
    assign wr_ctrl = REG_WR & hit_ctrl;

    assign fifo_en = ctrl_ff[uifc_pkg::CTRL_FIFO_EN_BIT];
    assign auto_flow = ctrl_ff[uifc_pkg::CTRL_AUTO_FLOW_BIT];
    assign rts_req = ctrl_ff[uifc_pkg::CTRL_RTS_REQ_BIT];

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            irq_en_ff <= uifc_pkg::IER_RESET;
        else if (wr_ier)
            irq_en_ff <= REG_WDATA[2:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            div_high_ff <= uifc_pkg::DIV_HIGH_RESET;
        else if (wr_div)
            div_high_ff <= REG_WDATA[7:0];
    end

    // write-only thresholds; the read side of this address differs
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            rx_thr_ff <= uifc_pkg::THR_RESET;
            tx_thr_ff <= uifc_pkg::THR_RESET;
        end
        else if (wr_fcr)
        begin
            rx_thr_ff <= REG_WDATA[uifc_pkg::FCR_RX_THR_LSB +: 2];
            tx_thr_ff <= REG_WDATA[uifc_pkg::FCR_TX_THR_LSB +: 2];
        end
    end

    // mode bit rides on the same write as the thresholds
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            dma_mode_ff <= 1'b0;
        else if (wr_fcr)
            dma_mode_ff <= REG_WDATA[uifc_pkg::FCR_DMA_MODE_BIT];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            lcr_ff <= uifc_pkg::LCR_RESET;
        else if (wr_lcr)
            lcr_ff <= REG_WDATA[7:0];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            ctrl_ff <= uifc_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_ff <= REG_WDATA[2:0];
    end

    // threshold decode
    always_comb
    begin
        case (rx_thr_ff)
            2'b00: rx_level = uifc_pkg::RX_LVL_ONE;
            2'b01: rx_level = uifc_pkg::RX_LVL_QUARTER;
            2'b10: rx_level = uifc_pkg::RX_LVL_HALF;
            2'b11: rx_level = uifc_pkg::RX_LVL_NEAR_FULL;
            default: rx_level = uifc_pkg::RX_LVL_ONE;
        endcase
    end

    always_comb
    begin
        case (tx_thr_ff)
            2'b00: tx_level = uifc_pkg::TX_LVL_EMPTY;
            2'b01: tx_level = uifc_pkg::TX_LVL_TWO;
            2'b10: tx_level = uifc_pkg::TX_LVL_QUARTER;
            2'b11: tx_level = uifc_pkg::TX_LVL_HALF;
            default: tx_level = uifc_pkg::TX_LVL_EMPTY;
        endcase
    end

    assign rx_any = (RX_FIFO_LEVEL != 5'h00);
    assign tx_empty = (TX_FIFO_LEVEL == 5'h00);
    assign rx_at_thr = (RX_FIFO_LEVEL >= rx_level);
    assign tx_at_thr = (TX_FIFO_LEVEL <= tx_level);

    // without fifos a single character is the threshold
    assign line_pend = LINE_STATUS_EVENT;
    assign rx_pend = fifo_en ? rx_at_thr : rx_any;
    assign timeout_pend = fifo_en & CHAR_TIMEOUT_EVENT;
    assign txe_pend = fifo_en ? tx_at_thr : tx_empty;

    assign line_on = line_pend & irq_en_ff[uifc_pkg::IER_LINE_BIT];
    assign rx_on = (rx_pend | timeout_pend)
        & irq_en_ff[uifc_pkg::IER_RX_DATA_BIT];
    assign txe_on = txe_pend & irq_en_ff[uifc_pkg::IER_TX_EMPTY_BIT];

    // fixed priority: line, then rx data/timeout, then tx empty
    always_comb
    begin
        if (line_on)
            nxt_src = uifc_pkg::SRC_LINE;
        else if (rx_on)
            nxt_src = uifc_pkg::SRC_RX_DATA;
        else if (txe_on)
            nxt_src = uifc_pkg::SRC_TX_EMPTY;
        else
            nxt_src = uifc_pkg::SRC_NONE;
    end

    assign nxt_irq = line_on | rx_on | txe_on;

    // auto flow overrides the software request at the threshold
    assign nxt_rts_n = (auto_flow & fifo_en & rx_at_thr) | ~rts_req;

    // mode 0 asks per character, mode 1 waits for the threshold
    assign nxt_dma_rx_n = dma_mode_ff ? ~(fifo_en & rx_at_thr)
        : ~rx_any;
    assign nxt_dma_tx_n = dma_mode_ff ? ~txe_pend : ~tx_empty;

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            irq_ff <= 1'b0;
        else
            irq_ff <= nxt_irq;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            src_ff <= uifc_pkg::SRC_NONE;
        else
            src_ff <= nxt_src;
    end

    // request lines idle high, so reset leaves the far end unasked
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            rts_n_ff <= 1'b1;
        else
            rts_n_ff <= nxt_rts_n;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            dma_rx_n_ff <= 1'b1;
        else
            dma_rx_n_ff <= nxt_dma_rx_n;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            dma_tx_n_ff <= 1'b1;
        else
            dma_tx_n_ff <= nxt_dma_tx_n;
    end

    // read views
    assign ier_view = div_access ? div_high_ff
        : {5'h00, irq_en_ff};
    assign fcr_view = {(fifo_en ? uifc_pkg::FIFO_STATUS_ON
        : uifc_pkg::FIFO_STATUS_OFF), 6'h00};
    assign status_view = {1'b0, txe_pend, timeout_pend, rx_pend,
        line_pend, irq_ff, src_ff};

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (REG_RD)
        begin
            if (hit_ier)
                nxt_rdata = {24'h00_0000, ier_view};
            else if (hit_fcr)
                nxt_rdata = {24'h00_0000, fcr_view};
            else if (hit_lcr)
                nxt_rdata = {24'h00_0000, lcr_ff};
            else if (hit_ctrl)
                nxt_rdata = {29'h0000_0000, ctrl_ff};
            else if (hit_status)
                nxt_rdata = {24'h00_0000, status_view};
            else
                nxt_rdata = 32'h0000_0000;
        end
    end

    // data is valid only in the cycle after the read strobe
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            rdata_ff <= 32'h0000_0000;
        else
            rdata_ff <= nxt_rdata;
    end

    // receive character path through the two-entry buffer
    uifc_stream_if rx_st ();

    assign rx_st.in_valid = RX_IN_VALID;
    assign rx_st.in_data = RX_IN_DATA;
    assign rx_st.out_ready = RX_OUT_READY;

    uifc_buffer u_rx_buf (
        .clk(SYS_CLK),
        .rst(RESET),
        .st(rx_st.buffer)
    );

    assign REG_RDATA = rdata_ff;
    assign IRQ = irq_ff;
    assign IRQ_SOURCE = src_ff;
    assign RTS_N = rts_n_ff;
    assign DMA_RX_REQ_N = dma_rx_n_ff;
    assign DMA_TX_REQ_N = dma_tx_n_ff;
    assign DIVISOR_HIGH = div_high_ff;
    assign RX_THRESHOLD = rx_thr_ff;
    assign TX_THRESHOLD = tx_thr_ff;
    assign RX_IN_READY = rx_st.in_ready;
    assign RX_OUT_VALID = rx_st.out_valid;
    assign RX_OUT_DATA = rx_st.out_data;
endmodule
`default_nettype wire

// [verif/uifc_top_asserts.sv]
// checker for the enable / divisor / fifo-control slice
// assumes binding to uifc_top, single clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module uifc_top_asserts (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [31:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic LINE_STATUS_EVENT,
    input wire logic IRQ,
    input wire logic [1:0] IRQ_SOURCE,
    input wire logic [7:0] DIVISOR_HIGH,
    input wire logic [1:0] RX_THRESHOLD,
    input wire logic [1:0] TX_THRESHOLD
);
    logic divisor_access_bit_ff;
    logic fen_ff;
    logic [2:0] en_ff;
    wire logic wr_lcr = REG_WR && REG_ADDR == uifc_pkg::ADDR_LCR;
    wire logic wr_ier = REG_WR && REG_ADDR == uifc_pkg::ADDR_IER_DLH;
    wire logic wr_fcr = REG_WR && REG_ADDR == uifc_pkg::ADDR_IIR_FCR;
    wire logic wr_ctl = REG_WR && REG_ADDR == uifc_pkg::ADDR_CTRL;
    wire logic rd_fcr = REG_RD && REG_ADDR == uifc_pkg::ADDR_IIR_FCR;
    wire logic rd_ier = REG_RD && REG_ADDR == uifc_pkg::ADDR_IER_DLH;
    wire logic ln_on = LINE_STATUS_EVENT && en_ff[2];
    // shadow of the enables, so gating can be judged from ports
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            divisor_access_bit_ff <= 1'b0;
            fen_ff <= 1'b0;
            en_ff <= 3'h0;
        end
        else
        begin
            if (wr_lcr) divisor_access_bit_ff <= REG_WDATA[7];
            if (wr_ctl) fen_ff <= REG_WDATA[0];
            if (wr_ier && !divisor_access_bit_ff) en_ff <= REG_WDATA[2:0];
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    property p_line_top;
        ln_on && !REG_WR |=> IRQ_SOURCE == 2'b01;
    endproperty
    a_line_top: assert property (p_line_top) else $error("line not top");
    property p_rx_gate;
        IRQ_SOURCE == 2'b10 |-> $past(en_ff[0] && !ln_on);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("rx src bad");
    property p_tx_gate;
        IRQ_SOURCE == 2'b11 |-> $past(en_ff[1] && !ln_on);
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("tx src bad");
    property p_irq_src;
        IRQ == (IRQ_SOURCE != 2'b00);
    endproperty
    a_irq_src: assert property (p_irq_src) else $error("irq vs src");
    property p_irq_off;
        en_ff == 3'h0 && !wr_ier |=> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq unmasked");
    property p_dlh_wr;
        wr_ier && divisor_access_bit_ff |=> DIVISOR_HIGH == $past(REG_WDATA[7:0]);
    endproperty
    a_dlh_wr: assert property (p_dlh_wr) else $error("dlh write");
    property p_dlh_keep;
        wr_ier && !divisor_access_bit_ff |=> $stable(DIVISOR_HIGH);
    endproperty
    a_dlh_keep: assert property (p_dlh_keep) else $error("dlh hit");
    property p_dlh_rd;
        rd_ier && divisor_access_bit_ff |=> REG_RDATA == {24'h0, DIVISOR_HIGH};
    endproperty
    a_dlh_rd: assert property (p_dlh_rd) else $error("dlh read");
    property p_rx_thr;
        wr_fcr |=> RX_THRESHOLD == $past(REG_WDATA[7:6]);
    endproperty
    a_rx_thr: assert property (p_rx_thr) else $error("rx thr");
    property p_tx_thr;
        wr_fcr |=> TX_THRESHOLD == $past(REG_WDATA[5:4]);
    endproperty
    a_tx_thr: assert property (p_tx_thr) else $error("tx thr");
    property p_fcr_rd;
        rd_fcr |=> REG_RDATA == {24'h0, {2{fen_ff}}, 6'h00};
    endproperty
    a_fcr_rd: assert property (p_fcr_rd) else $error("fcr read");
    c_line: cover property (IRQ_SOURCE == 2'b01);
    c_dlh: cover property (wr_ier && divisor_access_bit_ff);
    c_fen: cover property (rd_fcr && fen_ff);
endmodule
bind uifc_top uifc_top_asserts u_uifc_top_asserts (
    .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .LINE_STATUS_EVENT(LINE_STATUS_EVENT),
    .IRQ(IRQ), .IRQ_SOURCE(IRQ_SOURCE), .DIVISOR_HIGH(DIVISOR_HIGH),
    .RX_THRESHOLD(RX_THRESHOLD), .TX_THRESHOLD(TX_THRESHOLD)
);
`default_nettype wire

// [verif/uifc_top_test.sv]
// self-checking bench for the enable / fifo-control slice
// assumes uifc_top on one 10 MHz clock, bench drives all ports
`timescale 1ns/1ps
`default_nettype none
module uifc_top_test;
    logic SYS_CLK = 1'b0;
    logic RESET = 1'b1;
    logic [31:0] REG_ADDR = 32'h0;
    logic [31:0] REG_WDATA = 32'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [4:0] RX_FIFO_LEVEL = 5'h00;
    logic [4:0] TX_FIFO_LEVEL = 5'h05;
    logic LINE_STATUS_EVENT = 1'b0;
    logic CHAR_TIMEOUT_EVENT = 1'b0;
    logic RX_IN_VALID = 1'b0;
    logic [7:0] RX_IN_DATA = 8'h00;
    logic RX_OUT_READY = 1'b0;
    wire logic [31:0] REG_RDATA;
    wire logic RX_IN_READY, RX_OUT_VALID, IRQ, RTS_N;
    wire logic DMA_RX_REQ_N, DMA_TX_REQ_N;
    wire logic [7:0] RX_OUT_DATA, DIVISOR_HIGH;
    wire logic [1:0] IRQ_SOURCE, RX_THRESHOLD, TX_THRESHOLD;
    int failures = 0;
    int cmp_count = 0;
    int n;
    logic [1:0] c;
    logic [4:0] lvl [4];
    logic [4:0] tlv [4];
    always #50 SYS_CLK = ~SYS_CLK;
    uifc_top u_uifc_top (
        .SYS_CLK(SYS_CLK), .RESET(RESET), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .RX_FIFO_LEVEL(RX_FIFO_LEVEL),
        .TX_FIFO_LEVEL(TX_FIFO_LEVEL), .LINE_STATUS_EVENT(LINE_STATUS_EVENT),
        .CHAR_TIMEOUT_EVENT(CHAR_TIMEOUT_EVENT), .RX_IN_VALID(RX_IN_VALID),
        .RX_IN_DATA(RX_IN_DATA), .RX_IN_READY(RX_IN_READY),
        .RX_OUT_VALID(RX_OUT_VALID), .RX_OUT_DATA(RX_OUT_DATA),
        .RX_OUT_READY(RX_OUT_READY), .IRQ(IRQ), .IRQ_SOURCE(IRQ_SOURCE),
        .RTS_N(RTS_N), .DMA_RX_REQ_N(DMA_RX_REQ_N),
        .DMA_TX_REQ_N(DMA_TX_REQ_N), .DIVISOR_HIGH(DIVISOR_HIGH),
        .RX_THRESHOLD(RX_THRESHOLD), .TX_THRESHOLD(TX_THRESHOLD)
    );
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge SYS_CLK);
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e,
                      input string nm);
        @(posedge SYS_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'b0;
        #1;
        chk(nm, e, REG_RDATA);
    endtask
    task automatic ev(input logic ln, input logic to, input logic [4:0] rl,
                      input logic [4:0] tl, input logic [1:0] src);
        @(posedge SYS_CLK);
        LINE_STATUS_EVENT <= ln;
        CHAR_TIMEOUT_EVENT <= to;
        RX_FIFO_LEVEL <= rl;
        TX_FIFO_LEVEL <= tl;
        tick(2);
        chk("irq_source", src, IRQ_SOURCE);
        chk("irq", src != 2'b00, IRQ);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge SYS_CLK);
        failures++;
        final_report();
    end
    initial
    begin
        lvl = '{uifc_pkg::RX_LVL_ONE, uifc_pkg::RX_LVL_QUARTER,
                uifc_pkg::RX_LVL_HALF, uifc_pkg::RX_LVL_NEAR_FULL};
        tlv = '{uifc_pkg::TX_LVL_EMPTY, uifc_pkg::TX_LVL_TWO,
                uifc_pkg::TX_LVL_QUARTER, uifc_pkg::TX_LVL_HALF};
        repeat (3) @(posedge SYS_CLK);
        RESET <= 1'b0;
        rd(uifc_pkg::ADDR_IER_DLH, 32'h0, "ier");
        rd(uifc_pkg::ADDR_IIR_FCR, 32'h0, "fcr");
        chk("rts_n", 1'b1, RTS_N);
        wr(32'h5000_1180, 32'hff);
        rd(32'h5000_1180, 32'h0, "unmapped");
        $display("test reset done");
        wr(uifc_pkg::ADDR_LCR, 32'h80);
        rd(uifc_pkg::ADDR_LCR, 32'h80, "lcr");
        wr(uifc_pkg::ADDR_IER_DLH, 32'ha5);
        rd(uifc_pkg::ADDR_IER_DLH, 32'ha5, "dlh");
        chk("divisor_high", 8'ha5, DIVISOR_HIGH);
        wr(uifc_pkg::ADDR_LCR, 32'h00);
        wr(uifc_pkg::ADDR_IER_DLH, 32'h07);
        rd(uifc_pkg::ADDR_IER_DLH, 32'h07, "ier");
        chk("divisor_high", 8'ha5, DIVISOR_HIGH);
        $display("test divisor done");
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            wr(uifc_pkg::ADDR_IIR_FCR, {24'h0, c, ~c, 4'h0});
            tick(1);
            chk("rx_thr", c, RX_THRESHOLD);
            chk("tx_thr", {30'h0, ~c}, TX_THRESHOLD);
            rd(uifc_pkg::ADDR_IIR_FCR, 32'h0, "fcr_off");
        end
        wr(uifc_pkg::ADDR_CTRL, 32'h1);
        rd(uifc_pkg::ADDR_IIR_FCR, 32'hc0, "fcr_on");
        $display("test thresholds done");
        wr(uifc_pkg::ADDR_IIR_FCR, 32'h0);
        ev(1'b1, 1'b0, 5'h01, 5'h00, 2'b01);
        chk("dma_rx_m0", 1'b0, DMA_RX_REQ_N);
        chk("dma_tx_m0", 1'b0, DMA_TX_REQ_N);
        rd(uifc_pkg::ADDR_STATUS, 32'h5d, "status");
        ev(1'b0, 1'b0, 5'h01, 5'h00, 2'b10);
        ev(1'b0, 1'b0, 5'h00, 5'h00, 2'b11);
        ev(1'b0, 1'b1, 5'h00, 5'h05, 2'b10);
        ev(1'b0, 1'b0, 5'h00, 5'h05, 2'b00);
        chk("dma_rx_m0_idle", 1'b1, DMA_RX_REQ_N);
        chk("dma_tx_m0_idle", 1'b1, DMA_TX_REQ_N);
        wr(uifc_pkg::ADDR_IER_DLH, 32'h02);
        ev(1'b1, 1'b1, 5'h01, 5'h00, 2'b11);
        wr(uifc_pkg::ADDR_IER_DLH, 32'h00);
        ev(1'b1, 1'b1, 5'h01, 5'h00, 2'b00);
        $display("test priority done");
        wr(uifc_pkg::ADDR_CTRL, 32'h7);
        rd(uifc_pkg::ADDR_CTRL, 32'h7, "ctrl");
        for (int i = 0; i < 4; i++)
        begin
            c = i[1:0];
            wr(uifc_pkg::ADDR_IIR_FCR, {24'h0, c, c, 4'h8});
            ev(1'b0, 1'b0, lvl[i] - 5'h01, tlv[i] + 5'h01, 2'b00);
            chk("rts_n_low", 1'b0, RTS_N);
            chk("dma_rx_idle", 1'b1, DMA_RX_REQ_N);
            chk("dma_tx_idle", 1'b1, DMA_TX_REQ_N);
            ev(1'b0, 1'b0, lvl[i], tlv[i], 2'b00);
            chk("rts_n_high", 1'b1, RTS_N);
            chk("dma_rx_req", 1'b0, DMA_RX_REQ_N);
            chk("dma_tx_req", 1'b0, DMA_TX_REQ_N);
        end
        $display("test flow done");
        @(posedge SYS_CLK);
        RESET <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        RESET <= 1'b0;
        #1;
        chk("divisor_rst", 8'h00, DIVISOR_HIGH);
        chk("rx_thr_rst", 2'h0, RX_THRESHOLD);
        chk("dma_rx_rst", 1'b1, DMA_RX_REQ_N);
        rd(uifc_pkg::ADDR_IER_DLH, 32'h0, "ier_rst");
        $display("test reset again done");
        // receiver stalls, so the buffer must refuse the third word
        @(posedge SYS_CLK);
        n = 0;
        RX_IN_VALID <= 1'b1;
        RX_IN_DATA <= 8'h31;
        repeat (6)
        begin
            @(posedge SYS_CLK);
            if (RX_IN_READY)
            begin
                n++;
                RX_IN_DATA <= 8'h31 + n[7:0];
            end
        end
        RX_IN_VALID <= 1'b0;
        chk("accepted", 2, n);
        RX_OUT_READY <= 1'b1;
        n = 0;
        repeat (5)
        begin
            @(posedge SYS_CLK);
            if (RX_OUT_VALID)
            begin
                chk("rx_out_data", 8'h31 + n[7:0], RX_OUT_DATA);
                n++;
            end
        end
        chk("drained", 2, n);
        tick(1);
        chk("rx_out_valid", 1'b0, RX_OUT_VALID);
        $display("test buffer done");
        final_report();
    end
endmodule
`default_nettype wire
